//--- ubg_top.sv
// top: baud divisor, shared bit-rate tick and character data registers
// Notes on behaviour
// - a free-running 16-bit timer whose period is set by the divisor register.
// - bit rate is the instruction clock over 16 times (divisor plus one).
// - every 16-bit divisor works, down to the instruction clock over 16 times 65536.
// - any divisor write clears the baud timer at once.
// - the divisor register is 16 bits read/write and resets to zero.
// - the baud period counts instruction-cycle enables, not raw clock cycles.
// - received ninth bit reads back at bit 8 of the receive register in 9-bit format.
// - received low byte reads at bits 7 to 0, all reset to zero.
// - bits 15 to 9 of receive and transmit data registers read as zero.
// - the transmit data register is write-only with no readback.
// - the transmit ninth bit is taken from bit 8 of the written word in 9-bit format.
// - the transmit low byte is taken from bits 7 to 0 of the written word.
// - disabling resets the baud counter and empties buffers but keeps the divisor.
// - transmitter and receiver share one format and one bit rate.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ubg_top
  import ubg_pkg::*;
#(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cy_en,
  // register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  // shared rate and format
  output logic             o_ovs_tick,
  output logic             o_bit_tick,
  output logic      [1:0]  o_fmt_sel,
  output logic             o_module_enable,
  output logic             o_buf_flush,
  // transmit buffer write port
  output logic             o_tx_push,
  output logic      [8:0]  o_tx_char,
  // receive buffer read port
  input  wire logic [8:0]  i_rx_char,
  input  wire logic        i_rx_valid,
  output logic             o_rx_pop
);
  // refuse widths that the fixed register layout cannot serve
  if (DIV_W != 16) begin : g_bad_width
    $error("divisor width must be 16");
  end

  logic [15:0] div_reg;
  logic        en_reg;
  logic [1:0]  fmt_reg;
  logic [8:0]  rx_reg;
  logic [8:0]  tx_reg;
  logic        push_reg;
  logic        pop_reg;
  logic [15:0] rdata_reg;
  logic [3:0]  ovs_reg;
  logic        en_d_reg;

  // decode
  wire wr_div  = i_reg_wr & (i_reg_addr == UBG_OFS_DIV);
  wire wr_tx   = i_reg_wr & (i_reg_addr == UBG_OFS_TX);
  wire wr_ctrl = i_reg_wr & (i_reg_addr == UBG_OFS_CTRL);
  wire rd_rx   = i_reg_rd & (i_reg_addr == UBG_OFS_RX);
  wire dis_evt = en_d_reg & ~en_reg;
  wire tmr_clr = wr_div | ~en_reg;
  wire tick16;
  wire nine    = (fmt_reg == UBG_FMT_NINE);
  // next words of the data registers, ninth bit kept only in 9-bit format
  wire [8:0] tx_next = {i_reg_wdata[UBG_NINTH_POS] & nine, i_reg_wdata[7:0]};
  wire [8:0] rx_next = {i_rx_char[8] & nine, i_rx_char[7:0]};

  // read mux, tx reads zero, unmapped reads zero
  logic [15:0] rdata_next;
  always_comb begin
    rdata_next = 16'h0000;
    unique case (i_reg_addr)
      UBG_OFS_RX:   rdata_next = {7'h00, rx_reg};
      UBG_OFS_TX:   rdata_next = 16'h0000;
      UBG_OFS_DIV:  rdata_next = div_reg;
      UBG_OFS_CTRL: rdata_next = {13'h0000, fmt_reg, en_reg};
      default:      rdata_next = 16'h0000;
    endcase
  end

  // baud timer, stepped by the instruction-cycle enable
  ubg_tick_div #(.WIDTH(DIV_W)) i_ubg_tick_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_clear   (tmr_clr),
    .i_step    (i_cy_en),
    .i_limit   (div_reg),
    .o_tick    (tick16)
  );

  // divisor register, kept across a disable
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg <= UBG_DIV_RST;
    end else if (wr_div) begin
      div_reg <= i_reg_wdata;
    end
  end

  // control register: enable bit, its delayed copy and format
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_reg   <= 1'b0;
      en_d_reg <= 1'b0;
      fmt_reg  <= UBG_FMT_RST;
    end else begin
      en_d_reg <= en_reg;
      if (wr_ctrl) begin
        en_reg  <= i_reg_wdata[UBG_EN_POS];
        fmt_reg <= i_reg_wdata[UBG_FMT_LSB +: 2];
      end
    end
  end

  // read data, taken on a read strobe and held until the next one
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 16'h0000;
    end else if (i_reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // transmit word, loaded on any transmit write, and its one-cycle push, refused while disabled
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_reg   <= 9'h000;
      push_reg <= 1'b0;
    end else begin
      push_reg <= wr_tx & en_reg;
      if (wr_tx) begin
        tx_reg <= tx_next;
      end
    end
  end

  // receive word, loaded at each pop and zeroed while disabled
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_reg  <= UBG_RX_RST;
      pop_reg <= 1'b0;
    end else begin
      pop_reg <= rd_rx & i_rx_valid & en_reg;
      if (!en_reg) begin
        rx_reg <= UBG_RX_RST;
      end else if (rd_rx && i_rx_valid) begin
        rx_reg <= rx_next;
      end
    end
  end

  // oversample counter, one bit tick per sixteen ticks
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovs_reg <= 4'h0;
    end else if (tmr_clr) begin
      ovs_reg <= 4'h0;
    end else if (tick16) begin
      ovs_reg <= ovs_reg + 4'h1;
    end
  end

  // outputs
  assign o_reg_rdata     = rdata_reg;
  assign o_ovs_tick      = tick16;
  assign o_bit_tick      = tick16 & (ovs_reg == UBG_OVS_LAST);
  assign o_fmt_sel       = fmt_reg;
  assign o_module_enable = en_reg;
  assign o_buf_flush     = dis_evt | ~en_reg;
  assign o_tx_push       = push_reg;
  assign o_tx_char       = tx_reg;
  assign o_rx_pop        = pop_reg;

  // divisor write restarts the timer, so no tick in the next cycle for a nonzero divisor
  property p_div_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_div && i_reg_wdata != 16'h0000) |=> !o_ovs_tick;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("tick right after divisor write");

  property p_zero_div;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (div_reg == 16'h0000 && en_reg && i_cy_en && !tmr_clr) |-> o_ovs_tick;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("divisor zero must tick every enable");

  property p_no_step;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_cy_en |-> !o_ovs_tick;
  endproperty
  a_no_step: assert property (p_no_step) else $error("tick without cycle enable");

  property p_disabled;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      !en_reg |-> (!o_ovs_tick && o_buf_flush);
  endproperty
  a_disabled: assert property (p_disabled) else $error("activity while disabled");

  property p_keep_div;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!wr_div) |=> (div_reg == $past(div_reg));
  endproperty
  a_keep_div: assert property (p_keep_div) else $error("divisor changed without write");

  property p_tx_rd;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_reg_rd && i_reg_addr == UBG_OFS_TX) |=> (o_reg_rdata == 16'h0000);
  endproperty
  a_tx_rd: assert property (p_tx_rd) else $error("transmit register read back data");

  property p_rx_hi;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_reg_rd && i_reg_addr == UBG_OFS_RX) |=> (o_reg_rdata[15:9] == 7'h00);
  endproperty
  a_rx_hi: assert property (p_rx_hi) else $error("receive upper bits not zero");

  property p_tx_data;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_tx && en_reg) |=> (o_tx_push && o_tx_char[7:0] == $past(i_reg_wdata[7:0]));
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("transmit byte not forwarded");

  property p_bit_tick;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_bit_tick |-> o_ovs_tick;
  endproperty
  a_bit_tick: assert property (p_bit_tick) else $error("bit tick off oversample grid");

  // no tick in the cycle that writes the divisor
  property p_div_wr_tick;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      wr_div |-> !o_ovs_tick;
  endproperty
  a_div_wr_tick: assert property (p_div_wr_tick) else $error("tick in divisor write cycle");

  // oversample count restarts with the timer
  property p_ovs_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      tmr_clr |=> (ovs_reg == 4'h0);
  endproperty
  a_ovs_clear: assert property (p_ovs_clear) else $error("oversample count not restarted");

  // divisor write lands whole
  property p_div_load;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      wr_div |=> (div_reg == $past(i_reg_wdata));
  endproperty
  a_div_load: assert property (p_div_load) else $error("divisor write lost");

  // divisor reads back over its full width
  property p_div_rd;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_reg_rd && i_reg_addr == UBG_OFS_DIV) |=> (o_reg_rdata == $past(div_reg));
  endproperty
  a_div_rd: assert property (p_div_rd) else $error("divisor read back wrong");

  // receive read returns the held character
  property p_rx_rd;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      rd_rx |=> (o_reg_rdata[8:0] == $past(rx_reg));
  endproperty
  a_rx_rd: assert property (p_rx_rd) else $error("receive read wrong");

  // ninth received bit kept in 9-bit format
  property p_rx_ninth;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (rd_rx && i_rx_valid && en_reg && nine) |=> (rx_reg[8] == $past(i_rx_char[8]));
  endproperty
  a_rx_ninth: assert property (p_rx_ninth) else $error("received ninth bit lost");

  // ninth transmit bit forwarded in 9-bit format
  property p_tx_ninth;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_tx && nine) |=> (o_tx_char[8] == $past(i_reg_wdata[8]));
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("transmit ninth bit lost");

  // a read of a waiting character pops it
  property p_pop;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (rd_rx && i_rx_valid && en_reg) |=> o_rx_pop;
  endproperty
  a_pop: assert property (p_pop) else $error("receive read did not pop");

  // no push while disabled
  property p_dis_push;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      !en_reg |=> !o_tx_push;
  endproperty
  a_dis_push: assert property (p_dis_push) else $error("push while disabled");

  // receive word emptied while disabled
  property p_dis_rx;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      !en_reg |=> (rx_reg == UBG_RX_RST);
  endproperty
  a_dis_rx: assert property (p_dis_rx) else $error("receive word kept while disabled");
endmodule // ubg_top
`default_nettype wire

//--- ubg_pkg.sv
// package: register map, field layout and reset values of the baud generator block
package ubg_pkg;
  // register word offsets on the plain register port
  localparam logic [3:0]  UBG_OFS_RX     = 4'h0;
  localparam logic [3:0]  UBG_OFS_TX     = 4'h1;
  localparam logic [3:0]  UBG_OFS_DIV    = 4'h2;
  localparam logic [3:0]  UBG_OFS_CTRL   = 4'h3;
  // field positions
  localparam int          UBG_NINTH_POS  = 8;
  localparam int          UBG_EN_POS     = 0;
  localparam int          UBG_FMT_LSB    = 1;
  // reset values
  localparam logic [15:0] UBG_DIV_RST    = 16'h0000;
  localparam logic [8:0]  UBG_RX_RST     = 9'h000;
  localparam logic [1:0]  UBG_FMT_RST    = 2'h0;
  // last oversample count of a bit (the generator runs at sixteen times the bit rate) and the 9-bit format code
  localparam logic [3:0]  UBG_OVS_LAST   = 4'hf;
  localparam logic [1:0]  UBG_FMT_NINE   = 2'h3;
endpackage : ubg_pkg

//--- ubg_tick_div.sv
// free-running divider that pulses once per (limit + 1) enabled cycles
`timescale 1ns/1ps
`default_nettype none
module ubg_tick_div #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  // control
  input  wire logic             i_clear,
  input  wire logic             i_step,
  input  wire logic [WIDTH-1:0] i_limit,
  // tick
  output logic                  o_tick
);
  // refuse a width that leaves no counter
  if (WIDTH < 1) begin : g_bad_width
    $error("width must be at least one");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              at_limit = (count_reg >= i_limit);

  // reload to zero at the limit, otherwise count up
  assign count_next = at_limit ? '0 : count_reg + WIDTH'(1);
  assign o_tick     = i_step & at_limit & ~i_clear;

  // counter, cleared at once by i_clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg <= '0;
    end else if (i_clear) begin
      count_reg <= '0;
    end else if (i_step) begin
      count_reg <= count_next;
    end
  end
endmodule // ubg_tick_div
`default_nettype wire

//--- ubg_rx_feed.sv
// receive buffer head model feeding two characters to the block
`timescale 1ns/1ps
`default_nettype none
module ubg_rx_feed (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // buffer read port
  input  wire logic       i_pop,
  output logic      [8:0] o_rx_char,
  output logic            o_rx_valid
);
  logic [1:0] ptr_reg;
  // head advances on each pop, empty after two
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) ptr_reg <= 2'h0;
    else if (i_pop && o_rx_valid) ptr_reg <= ptr_reg + 2'h1;
  end
  assign o_rx_valid = (ptr_reg < 2'h2);
  // empty head shows the inverse of the last character
  assign o_rx_char  = (ptr_reg == 2'h0) ? 9'h1c5 : (ptr_reg == 2'h1) ? 9'h03a : 9'h1c5;
endmodule // ubg_rx_feed
`default_nettype wire

//--- ubg_top_tb.sv
// self-checking bench for the baud generator and data registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module ubg_top_tb;
  import ubg_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic        cy_en     = 1'b1;
  logic        cy_half   = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [15:0] wdata     = 16'h0000;
  logic        wr_s      = 1'b0;
  logic        rd_s      = 1'b0;
  logic [15:0] rdata;
  logic        ovs, bit_t, en, flush, push, pop, rx_valid;
  logic [1:0]  fmt;
  logic [8:0]  tx_char, rx_char;
  int          errors = 0;
  int          samples_checked = 0;
  int          n_ovs, n_bit;
  int          divs [3] = '{0, 2, 5};
  logic [15:0] d;
  // clock and instruction-cycle enable
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cy_en <= cy_half ? ~cy_en : 1'b1;
  ubg_top i_ubg_top (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cy_en(cy_en), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .o_ovs_tick(ovs),
    .o_bit_tick(bit_t), .o_fmt_sel(fmt), .o_module_enable(en), .o_buf_flush(flush), .o_tx_push(push),
    .o_tx_char(tx_char), .i_rx_char(rx_char), .i_rx_valid(rx_valid), .o_rx_pop(pop));
  ubg_rx_feed i_ubg_rx_feed (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_pop(pop),
    .o_rx_char(rx_char), .o_rx_valid(rx_valid));
  // one-cycle register write, then one idle cycle so registered outputs settle
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge i_sys_clk);
    wr_s <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_sys_clk);
    rd_s <= 1'b0;
    @(posedge i_sys_clk);
    v = rdata;
  endtask
  // count ticks over a window of cycles
  task automatic cnt(input int n);
    n_ovs = 0;
    n_bit = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      n_ovs += int'(ovs);
      n_bit += int'(bit_t);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(posedge i_sys_clk);
    `CHK("flush", 1'b1, flush)
    rd(UBG_OFS_DIV, d); `CHK("div rst", UBG_DIV_RST, d)
    rd(UBG_OFS_TX, d); `CHK("tx read", 16'h0000, d)
    rd(4'hf, d); `CHK("unmapped", 16'h0000, d)
    wr(UBG_OFS_DIV, 16'ha5c3);
    rd(UBG_OFS_DIV, d); `CHK("div rw", 16'ha5c3, d)
    wr(UBG_OFS_CTRL, 16'h0001);
    `CHK("enable", 1'b1, en)
    foreach (divs[i]) begin
      wr(UBG_OFS_DIV, 16'(divs[i]));
      cnt(32 * (divs[i] + 1));
      `CHK("ovs count", 32, n_ovs)
      `CHK("bit count", 2, n_bit)
    end
    cy_half <= 1'b1;
    wr(UBG_OFS_DIV, 16'h0002);
    cnt(192);
    `CHK("ovs half", 32, n_ovs)
    cy_half <= 1'b0;
    wr(UBG_OFS_DIV, 16'hffff);
    cnt(1000);
    `CHK("ovs max div", 0, n_ovs)
    wr(UBG_OFS_DIV, 16'h0400);
    cnt(600);
    wr(UBG_OFS_DIV, 16'h0003);
    cnt(3);
    `CHK("ovs after rewrite", 1, n_ovs)
    wr(UBG_OFS_CTRL, 16'h0000);
    cnt(50);
    `CHK("ovs disabled", 0, n_ovs)
    `CHK("flush", 1'b1, flush)
    rd(UBG_OFS_DIV, d); `CHK("div kept", 16'h0003, d)
    wr(UBG_OFS_TX, 16'h0012);
    `CHK("push off", 1'b0, push)
    wr(UBG_OFS_CTRL, 16'h0007);
    `CHK("fmt", UBG_FMT_NINE, fmt)
    wr(UBG_OFS_TX, 16'hfdab);
    `CHK("push 9", 1'b1, push)
    `CHK("tx char 9", 9'h1ab, tx_char)
    rd(UBG_OFS_RX, d); `CHK("rx first", 16'h0000, d)
    `CHK("pop", 1'b1, pop)
    rd(UBG_OFS_RX, d); `CHK("rx ninth", 16'h01c5, d)
    rd(UBG_OFS_RX, d); `CHK("rx byte", 16'h003a, d)
    `CHK("pop empty", 1'b0, pop)
    wr(UBG_OFS_CTRL, 16'h0001);
    wr(UBG_OFS_TX, 16'h0155);
    `CHK("tx char 8", 9'h055, tx_char)
    rd(UBG_OFS_TX, d); `CHK("tx no readback", 16'h0000, d)
    stop_test();
  end
endmodule // ubg_top_tb
`default_nettype wire
